// *** src/misc_system_instr_exec.sv ***
`timescale 1ns/1ns
module misc_system_instr_exec (
  input wire logic clk, // Core clock, 10 MHz.
  input wire logic reset, // Synchronous active-high reset.
  input wire misc_sys_pkg::instr_s instr, // Instruction from decode.
  input wire logic privileged, // Core is in privileged mode.
  input wire logic mem_later_pending, // A later memory access waits to issue.
  input wire logic mem_outstanding, // Earlier explicit accesses not complete.
  input wire logic exc_unmasked, // Unmasked exception is ready to take.
  input wire logic exc_any, // Any exception occurs, masked or not.
  input wire logic exc_new_pending, // Exception just entered pending.
  input wire logic send_on_pending_bit, // Wake on new pending exception.
  input wire logic debug_req, // Debug entry request.
  input wire logic debug_enabled, // Debug is enabled.
  input wire logic ext_event, // Event pin from outside, asynchronous.
  output logic instr_ready, // Block accepts the presented instruction.
  output logic mem_issue_allow, // Later memory accesses may issue.
  output logic pipeline_flush, // One-cycle refetch request.
  output logic sleeping, // Core execution is suspended.
  output logic halted, // Core is in debug halt.
  output logic [7:0] breakpoint_instr_imm, // Immediate of the last breakpoint.
  output logic svc_req, // One-cycle supervisor call exception request.
  output logic [7:0] svc_imm, // Immediate kept for the handler.
  output logic sev_out, // One-cycle event to other processors.
  output logic [31:0] rd_data, // Special register read result.
  output logic rd_valid, // Read result valid, one cycle.
  output logic prio_mask, // Interrupt priority mask.
  output logic fault_mask, // Fault mask.
  output logic [7:0] base_prio, // Base priority mask.
  output logic [31:0] program_status_reg, // Program status register.
  output logic event_reg // Local event register.
);

  misc_sys_pkg::state_s st_ff;
  misc_sys_pkg::state_s nxt_st;
  logic executes;
  logic ev_seen;
  logic [31:0] psr_mask;

  // The breakpoint ignores its condition; everything else needs a pass.
  assign executes = instr.valid && (instr.cond_pass || instr.op == misc_sys_pkg::OP_BREAKPOINT);
  // The external event is read only after its second flop.
  assign ev_seen = st_ff.ev_sync[1] && !st_ff.ev_sync[2];
  // Only a privileged write of the whole status word reaches past the flag field.
  assign psr_mask = (privileged && instr.sreg == misc_sys_pkg::SR_PROG_STATUS) ? 32'hFFFF_FFFF
                    : misc_sys_pkg::APP_STATUS_MASK;

  // Next-state logic for every instruction of the group.
  always_comb begin
    nxt_st = st_ff;
    nxt_st.rd_valid = 1'b0;
    nxt_st.svc_req = 1'b0;
    nxt_st.sev_out = 1'b0;
    nxt_st.flush = 1'b0;
    nxt_st.ev_sync = {st_ff.ev_sync[1:0], ext_event};
    if (ev_seen) begin
      nxt_st.event_reg = 1'b1;
    end
    instr_ready = 1'b0;
    unique case (st_ff.seq)
      misc_sys_pkg::ST_RUN, misc_sys_pkg::ST_DRAIN_DMB: begin
        // Non-memory instructions keep executing while a memory barrier drains.
        // A sleep or halt begun mid-drain ends the drain early; a known limitation.
        instr_ready = 1'b1;
        if (st_ff.seq == misc_sys_pkg::ST_DRAIN_DMB && !mem_outstanding) begin
          nxt_st.seq = misc_sys_pkg::ST_RUN;
        end
        if (executes) begin
          unique case (instr.op)
            misc_sys_pkg::OP_BREAKPOINT: begin
              nxt_st.seq = misc_sys_pkg::ST_HALTED;
              nxt_st.breakpoint_instr_imm = instr.imm;
            end
            misc_sys_pkg::OP_CHANGE_STATE: begin
              if (privileged) begin
                if (instr.sel_prio) begin
                  nxt_st.prio_mask = instr.disable_form;
                end
                if (instr.sel_fault) begin
                  nxt_st.fault_mask = instr.disable_form;
                end
              end
            end
            misc_sys_pkg::OP_DMB: begin
              if (mem_outstanding) begin
                nxt_st.seq = misc_sys_pkg::ST_DRAIN_DMB;
              end
            end
            misc_sys_pkg::OP_DSB: begin
              instr_ready = !mem_outstanding;
              if (mem_outstanding) begin
                nxt_st.seq = misc_sys_pkg::ST_DRAIN_DSB;
              end
            end
            misc_sys_pkg::OP_ISB: begin
              nxt_st.flush = 1'b1;
            end
            misc_sys_pkg::OP_READ_SPECIAL: begin
              nxt_st.rd_valid = 1'b1;
              unique case (instr.sreg)
                misc_sys_pkg::SR_APP_STATUS: nxt_st.rd_data = st_ff.program_status_reg & misc_sys_pkg::APP_STATUS_MASK;
                misc_sys_pkg::SR_PROG_STATUS: nxt_st.rd_data = st_ff.program_status_reg;
                misc_sys_pkg::SR_PRIO_MASK: nxt_st.rd_data = {31'h0, st_ff.prio_mask};
                misc_sys_pkg::SR_FAULT_MASK: nxt_st.rd_data = {31'h0, st_ff.fault_mask};
                default: nxt_st.rd_data = {24'h0, st_ff.base_prio};
              endcase
            end
            misc_sys_pkg::OP_WRITE_SPECIAL: begin
              unique case (instr.sreg)
                misc_sys_pkg::SR_APP_STATUS, misc_sys_pkg::SR_PROG_STATUS: begin
                  // Flags come straight from the source word.
                  nxt_st.program_status_reg = (st_ff.program_status_reg & ~psr_mask) | (instr.src & psr_mask);
                end
                misc_sys_pkg::SR_PRIO_MASK: begin
                  if (privileged) nxt_st.prio_mask = instr.src[0];
                end
                misc_sys_pkg::SR_FAULT_MASK: begin
                  if (privileged) nxt_st.fault_mask = instr.src[0];
                end
                misc_sys_pkg::SR_BASE_PRIO: begin
                  if (privileged) nxt_st.base_prio = instr.src[7:0];
                end
                default: begin
                  if (privileged && instr.src[7:0] != 8'h00 && (st_ff.base_prio == 8'h00
                      || instr.src[7:0] < st_ff.base_prio)) begin
                    nxt_st.base_prio = instr.src[7:0];
                  end
                end
              endcase
            end
            misc_sys_pkg::OP_SEND_EVENT: begin
              nxt_st.sev_out = 1'b1;
              nxt_st.event_reg = 1'b1;
            end
            misc_sys_pkg::OP_SUPERVISOR_CALL: begin
              nxt_st.svc_req = 1'b1;
              nxt_st.svc_imm = instr.imm;
            end
            misc_sys_pkg::OP_WAIT_EVENT: begin
              if (st_ff.event_reg || ev_seen) begin
                // A new event in the very cycle of the clear survives it only when the event register was already set.
                nxt_st.event_reg = st_ff.event_reg && ev_seen;
              end else begin
                nxt_st.seq = misc_sys_pkg::ST_SLEEP_EVENT;
              end
            end
            misc_sys_pkg::OP_WAIT_INTERRUPT: begin
              nxt_st.seq = misc_sys_pkg::ST_SLEEP_INT;
            end
            misc_sys_pkg::OP_NOP: begin
              // Retires at once with no effect; decode may also drop it early.
              nxt_st.rd_valid = 1'b0;
            end
            default: begin
              // Empty slots retire in one cycle unchanged.
            end
          endcase
        end
      end
      misc_sys_pkg::ST_DRAIN_DSB: begin
        if (!mem_outstanding) nxt_st.seq = misc_sys_pkg::ST_RUN;
      end
      misc_sys_pkg::ST_SLEEP_EVENT: begin
        // Wake condition is consumed, so the event register stays clear.
        if (exc_unmasked || (exc_new_pending && send_on_pending_bit)
            || (debug_req && debug_enabled) || ev_seen) begin
          nxt_st.seq = misc_sys_pkg::ST_RUN;
          nxt_st.event_reg = 1'b0;
        end
      end
      misc_sys_pkg::ST_SLEEP_INT: begin
        if (exc_any || debug_req) nxt_st.seq = misc_sys_pkg::ST_RUN;
      end
      misc_sys_pkg::ST_HALTED: begin
        // Only reset leaves halt; no other input of this block releases it.
      end
      default: nxt_st.seq = misc_sys_pkg::ST_RUN;
    endcase
    if (reset) begin
      nxt_st = '0;
      nxt_st.seq = misc_sys_pkg::ST_RUN;
      nxt_st.program_status_reg = misc_sys_pkg::PSR_RESET;
      nxt_st.base_prio = misc_sys_pkg::BASE_PRIO_RESET;
    end
  end

  // Single register stage for all state.
  always_ff @(posedge clk) begin
    st_ff <= nxt_st;
  end

  // Memory accesses stall behind a draining barrier only.
  assign mem_issue_allow = !(st_ff.seq == misc_sys_pkg::ST_DRAIN_DMB
                             || st_ff.seq == misc_sys_pkg::ST_DRAIN_DSB);
  assign pipeline_flush = st_ff.flush;
  assign sleeping = st_ff.seq == misc_sys_pkg::ST_SLEEP_EVENT
                    || st_ff.seq == misc_sys_pkg::ST_SLEEP_INT;
  assign halted = st_ff.seq == misc_sys_pkg::ST_HALTED;
  assign breakpoint_instr_imm = st_ff.breakpoint_instr_imm;
  assign svc_req = st_ff.svc_req;
  assign svc_imm = st_ff.svc_imm;
  assign sev_out = st_ff.sev_out;
  assign rd_data = st_ff.rd_data;
  assign rd_valid = st_ff.rd_valid;
  assign prio_mask = st_ff.prio_mask;
  assign fault_mask = st_ff.fault_mask;
  assign base_prio = st_ff.base_prio;
  assign program_status_reg = st_ff.program_status_reg;
  assign event_reg = st_ff.event_reg;

  // A failing-condition breakpoint still halts.
  property p_breakpoint_instr_halt;
    @(posedge clk) disable iff (reset)
      (instr_ready && instr.valid && instr.op == misc_sys_pkg::OP_BREAKPOINT
       && st_ff.seq == misc_sys_pkg::ST_RUN) |=> halted;
  endproperty
  a_breakpoint_instr_halt: assert property (p_breakpoint_instr_halt) else $error("breakpoint did not halt");

  property p_cps_unpriv;
    @(posedge clk) disable iff (reset)
      (!privileged && instr.valid && instr.op == misc_sys_pkg::OP_CHANGE_STATE)
      |=> $stable(prio_mask) && $stable(fault_mask);
  endproperty
  a_cps_unpriv: assert property (p_cps_unpriv) else $error("unprivileged mask change");

  property p_cps_set;
    @(posedge clk) disable iff (reset)
      (privileged && executes && st_ff.seq == misc_sys_pkg::ST_RUN && instr.sel_prio
       && instr.op == misc_sys_pkg::OP_CHANGE_STATE) |=> prio_mask == $past(instr.disable_form);
  endproperty
  a_cps_set: assert property (p_cps_set) else $error("priority mask not updated");

  property p_dsb_hold;
    @(posedge clk) disable iff (reset)
      (st_ff.seq == misc_sys_pkg::ST_DRAIN_DSB) |-> !instr_ready && !mem_issue_allow;
  endproperty
  a_dsb_hold: assert property (p_dsb_hold) else $error("sync barrier let work through");

  property p_dmb_flow;
    @(posedge clk) disable iff (reset)
      (st_ff.seq == misc_sys_pkg::ST_DRAIN_DMB) |-> instr_ready && !mem_issue_allow;
  endproperty
  a_dmb_flow: assert property (p_dmb_flow) else $error("memory barrier misordered");

  property p_sev;
    @(posedge clk) disable iff (reset)
      sev_out |-> event_reg ##1 !sev_out;
  endproperty
  a_sev: assert property (p_sev) else $error("send event wrong");

  property p_wfe_set;
    @(posedge clk) disable iff (reset)
      (event_reg && !ev_seen && executes && st_ff.seq == misc_sys_pkg::ST_RUN
       && instr.op == misc_sys_pkg::OP_WAIT_EVENT) |=> !sleeping && !event_reg;
  endproperty
  a_wfe_set: assert property (p_wfe_set) else $error("wait event with event set slept");

  property p_wfi_wake;
    @(posedge clk) disable iff (reset)
      (st_ff.seq == misc_sys_pkg::ST_SLEEP_INT && debug_req) |=> !sleeping;
  endproperty
  a_wfi_wake: assert property (p_wfi_wake) else $error("debug request did not wake");

  property p_svc;
    @(posedge clk) disable iff (reset)
      svc_req |-> $past(instr.op) == misc_sys_pkg::OP_SUPERVISOR_CALL ##1 !svc_req;
  endproperty
  a_svc: assert property (p_svc) else $error("supervisor call pulse wrong");

  // A breakpoint inside a conditional block halts although its condition failed.
  property p_breakpoint_instr_block;
    @(posedge clk) disable iff (reset)
      (instr_ready && instr.valid && instr.in_cond_block && !instr.cond_pass
       && instr.op == misc_sys_pkg::OP_BREAKPOINT) |=> halted;
  endproperty
  a_breakpoint_instr_block: assert property (p_breakpoint_instr_block) else $error("breakpoint skipped");

  property p_halt_hold;
    @(posedge clk) disable iff (reset)
      halted |=> halted && breakpoint_instr_imm == $past(breakpoint_instr_imm);
  endproperty
  a_halt_hold: assert property (p_halt_hold) else $error("halt left early");

  property p_nop;
    @(posedge clk) disable iff (reset)
      (instr_ready && executes && instr.op == misc_sys_pkg::OP_NOP)
      |=> $stable(program_status_reg) && $stable(prio_mask) && $stable(fault_mask) && $stable(base_prio);
  endproperty
  a_nop: assert property (p_nop) else $error("no-operation had an effect");

  property p_flags;
    @(posedge clk) disable iff (reset)
      !(instr_ready && executes && instr.op == misc_sys_pkg::OP_WRITE_SPECIAL)
      |=> $stable(program_status_reg);
  endproperty
  a_flags: assert property (p_flags) else $error("flags changed");

  property p_isb;
    @(posedge clk) disable iff (reset)
      (instr_ready && executes && instr.op == misc_sys_pkg::OP_ISB) |=> pipeline_flush;
  endproperty
  a_isb: assert property (p_isb) else $error("no flush after barrier");

  property p_alias_zero;
    @(posedge clk) disable iff (reset)
      (instr_ready && executes && instr.op == misc_sys_pkg::OP_WRITE_SPECIAL
       && instr.sreg == misc_sys_pkg::SR_MAX_PRIO_ALIAS && instr.src[7:0] == 8'h00)
      |=> $stable(base_prio);
  endproperty
  a_alias_zero: assert property (p_alias_zero) else $error("zero alias write landed");

  property p_unpriv_write;
    @(posedge clk) disable iff (reset)
      (!privileged && instr_ready && executes && instr.op == misc_sys_pkg::OP_WRITE_SPECIAL)
      |=> $stable(prio_mask) && $stable(fault_mask) && $stable(base_prio);
  endproperty
  a_unpriv_write: assert property (p_unpriv_write) else $error("mask write landed");

  property p_unpriv_psr;
    @(posedge clk) disable iff (reset)
      (!privileged && instr_ready && executes && instr.op == misc_sys_pkg::OP_WRITE_SPECIAL)
      |=> (program_status_reg & ~misc_sys_pkg::APP_STATUS_MASK) == ($past(program_status_reg) & ~misc_sys_pkg::APP_STATUS_MASK);
  endproperty
  a_unpriv_psr: assert property (p_unpriv_psr) else $error("status bits written");

  property p_wfe_sleep;
    @(posedge clk) disable iff (reset)
      (!event_reg && !ev_seen && instr_ready && executes
       && instr.op == misc_sys_pkg::OP_WAIT_EVENT) |=> sleeping;
  endproperty
  a_wfe_sleep: assert property (p_wfe_sleep) else $error("wait event did not sleep");

  property p_dmb_later;
    @(posedge clk) disable iff (reset)
      (st_ff.seq == misc_sys_pkg::ST_DRAIN_DMB && mem_later_pending) |-> !mem_issue_allow;
  endproperty
  a_dmb_later: assert property (p_dmb_later) else $error("later access let through");

endmodule : misc_system_instr_exec

// *** src/misc_sys_pkg.sv ***
package misc_sys_pkg;

  // Operation codes presented by the decode stage.
  typedef enum logic [3:0] {
    OP_NONE,
    OP_BREAKPOINT,
    OP_CHANGE_STATE,
    OP_DMB,
    OP_DSB,
    OP_ISB,
    OP_READ_SPECIAL,
    OP_WRITE_SPECIAL,
    OP_NOP,
    OP_SEND_EVENT,
    OP_SUPERVISOR_CALL,
    OP_WAIT_EVENT,
    OP_WAIT_INTERRUPT
  } op_e;

  // Special register selectors.
  typedef enum logic [2:0] {
    SR_APP_STATUS,
    SR_PROG_STATUS,
    SR_PRIO_MASK,
    SR_FAULT_MASK,
    SR_BASE_PRIO,
    SR_MAX_PRIO_ALIAS
  } sreg_e;

  // Sequencer states.
  typedef enum logic [2:0] {
    ST_RUN,
    ST_DRAIN_DMB,
    ST_DRAIN_DSB,
    ST_SLEEP_EVENT,
    ST_SLEEP_INT,
    ST_HALTED
  } seq_e;

  // Field positions inside the 32-bit status word.
  localparam int FLAG_LSB = 27;
  localparam int FLAG_MSB = 31;
  localparam int EXC_LSB = 0;
  localparam int EXC_MSB = 8;
  localparam logic [31:0] APP_STATUS_MASK = 32'hF800_0000;
  localparam logic [31:0] PSR_RESET = 32'h0100_0000;
  localparam logic [7:0] BASE_PRIO_RESET = 8'h00;

  // One instruction handed over by the decode stage.
  typedef struct packed {
    logic valid;
    op_e op;
    logic cond_pass;
    logic in_cond_block;
    logic disable_form;
    logic sel_prio;
    logic sel_fault;
    sreg_e sreg;
    logic [31:0] src;
    logic [7:0] imm;
  } instr_s;

  // Architectural and sequencing state of the block.
  typedef struct packed {
    seq_e seq;
    logic prio_mask;
    logic fault_mask;
    logic [7:0] base_prio;
    logic [31:0] program_status_reg;
    logic event_reg;
    logic [31:0] rd_data;
    logic rd_valid;
    logic svc_req;
    logic [7:0] svc_imm;
    logic breakpoint_instr_req;
    logic [7:0] breakpoint_instr_imm;
    logic sev_out;
    logic flush;
    logic [2:0] ev_sync;
  } state_s;

endpackage : misc_sys_pkg

// *** verif/mem_partner.sv ***
`timescale 1ns/1ns
// Stand-in for the memory system: a start pulse leaves earlier accesses
// outstanding for a fixed number of cycles, like a slow bus would.
module mem_partner #(
  parameter int LATENCY = 5
) (
  input wire logic clk, // Core clock.
  input wire logic reset, // Synchronous active-high reset.
  input wire logic start, // Begin a batch of slow accesses.
  output logic mem_outstanding // Earlier accesses not yet complete.
);
  logic [7:0] count_ff;

  // Count down the remaining wait; zero means every access has landed.
  always_ff @(posedge clk) begin
    if (reset) begin
      count_ff <= 8'h00;
    end else if (start) begin
      count_ff <= 8'(LATENCY);
    end else if (count_ff != 8'h00) begin
      count_ff <= count_ff - 8'h01;
    end
  end

  assign mem_outstanding = (count_ff != 8'h00);
endmodule : mem_partner

// *** verif/testbench.sv ***
`timescale 1ns/1ns
module testbench;
  logic clk = 1'b0;
  logic reset = 1'b1;
  misc_sys_pkg::instr_s instr = '0;
  logic privileged = 1'b1, start = 1'b0, cp = 1'b1, icb = 1'b0;
  logic exc_unmasked = 1'b0, exc_any = 1'b0, exc_new_pending = 1'b0, ext_event = 1'b0;
  logic send_on_pending_bit = 1'b1, debug_req = 1'b0, debug_enabled = 1'b1, later = 1'b0;
  logic mem_outstanding, instr_ready, mem_issue_allow, pipeline_flush, sleeping, halted;
  logic svc_req, sev_out, rd_valid, prio_mask, fault_mask, event_reg;
  logic [7:0] breakpoint_instr_imm, svc_imm, base_prio;
  logic [31:0] rd_data, program_status_reg, exp_psr;
  logic [7:0] alias_in [4] = '{8'h00, 8'h70, 8'h90, 8'h30};
  logic [7:0] alias_exp [4] = '{8'h00, 8'h70, 8'h70, 8'h30};
  int miscompares = 0, num_checks = 0, waited = 0;

  always #50 clk = ~clk;

  // Device under test; the memory stand-in supplies the outstanding flag.
  misc_system_instr_exec u_misc_system_instr_exec (
    .clk(clk), .reset(reset), .instr(instr), .privileged(privileged),
    .mem_later_pending(later), .mem_outstanding(mem_outstanding),
    .exc_unmasked(exc_unmasked), .exc_any(exc_any), .exc_new_pending(exc_new_pending),
    .send_on_pending_bit(send_on_pending_bit), .debug_req(debug_req),
    .debug_enabled(debug_enabled), .ext_event(ext_event), .instr_ready(instr_ready),
    .mem_issue_allow(mem_issue_allow), .pipeline_flush(pipeline_flush),
    .sleeping(sleeping), .halted(halted), .breakpoint_instr_imm(breakpoint_instr_imm), .svc_req(svc_req),
    .svc_imm(svc_imm), .sev_out(sev_out), .rd_data(rd_data), .rd_valid(rd_valid),
    .prio_mask(prio_mask), .fault_mask(fault_mask), .base_prio(base_prio),
    .program_status_reg(program_status_reg), .event_reg(event_reg)
  );

  mem_partner #(.LATENCY(5)) u_mem_partner (
    .clk(clk), .reset(reset), .start(start), .mem_outstanding(mem_outstanding)
  );

  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic print_verdict();
    if (miscompares == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : print_verdict

  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask : idle

  // Present one instruction and hold it until taken; returns one cycle after.
  // An idle cycle comes first so valid never toggles twice in one step.
  task automatic run(input misc_sys_pkg::op_e op, input logic [2:0] sr,
                     input logic [31:0] src, input logic [2:0] f);
    @(negedge clk);
    instr = '{valid: 1'b1, op: op, cond_pass: cp, in_cond_block: icb, disable_form: f[2],
              sel_prio: f[1], sel_fault: f[0], sreg: misc_sys_pkg::sreg_e'(sr),
              src: src, imm: src[7:0]};
    #1; // Let the ready decode settle on the new instruction.
    waited = 0;
    while (instr_ready !== 1'b1 && waited < 100) begin
      @(negedge clk);
      waited++;
    end
    check(instr_ready, 1'b1);
    @(negedge clk);
    instr.valid = 1'b0;
  endtask : run

  // Wait a bounded time for the core to wake, then drop every wake source.
  task automatic wake_wait();
    waited = 0;
    while (sleeping !== 1'b0 && waited < 10) begin
      @(negedge clk);
      waited++;
    end
    check(sleeping, 0);
    {exc_unmasked, exc_any, exc_new_pending, debug_req, ext_event} = 5'h00;
    idle(4);
  endtask : wake_wait

  // Start a slow batch of earlier memory accesses in the partner.
  task automatic kick();
    start = 1'b1;
    idle(1);
    start = 1'b0;
  endtask : kick

  // Only the flag bits survive a restricted status write.
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] src);
    return (old & ~misc_sys_pkg::APP_STATUS_MASK) | (src & misc_sys_pkg::APP_STATUS_MASK);
  endfunction : merge

  // Main sequence of scenarios.
  initial begin
    idle(6);
    reset = 1'b0;
    check({halted, sleeping, prio_mask, fault_mask, event_reg, program_status_reg},
          {5'h00, misc_sys_pkg::PSR_RESET});
    privileged = 1'b0;
    run(misc_sys_pkg::OP_CHANGE_STATE, 0, 0, 3'b111);
    check({prio_mask, fault_mask}, 0);
    run(misc_sys_pkg::OP_WRITE_SPECIAL, misc_sys_pkg::SR_BASE_PRIO, 32'h80, 0);
    check(base_prio, 0);
    run(misc_sys_pkg::OP_WRITE_SPECIAL, misc_sys_pkg::SR_PROG_STATUS, 32'h5FFF_FFFF, 0);
    exp_psr = merge(misc_sys_pkg::PSR_RESET, 32'h5FFF_FFFF);
    check(program_status_reg, exp_psr);
    privileged = 1'b1;
    run(misc_sys_pkg::OP_WRITE_SPECIAL, misc_sys_pkg::SR_APP_STATUS, 32'hA000_0000, 0);
    exp_psr = merge(exp_psr, 32'hA000_0000);
    check(program_status_reg, exp_psr);
    run(misc_sys_pkg::OP_WRITE_SPECIAL, misc_sys_pkg::SR_PROG_STATUS, 32'h2100_0003, 0);
    exp_psr = 32'h2100_0003;
    check(program_status_reg, exp_psr);
    run(misc_sys_pkg::OP_READ_SPECIAL, misc_sys_pkg::SR_APP_STATUS, 0, 0);
    check(rd_data, 32'h2000_0000);
    run(misc_sys_pkg::OP_CHANGE_STATE, 0, 0, 3'b110);
    check({prio_mask, fault_mask}, 2'b10);
    run(misc_sys_pkg::OP_CHANGE_STATE, 0, 0, 3'b101);
    check({prio_mask, fault_mask}, 2'b11);
    run(misc_sys_pkg::OP_CHANGE_STATE, 0, 0, 3'b011);
    check({prio_mask, fault_mask}, 2'b00);
    for (int i = 0; i < 4; i++) begin
      run(misc_sys_pkg::OP_WRITE_SPECIAL, misc_sys_pkg::SR_MAX_PRIO_ALIAS, alias_in[i], 0);
      check(base_prio, alias_exp[i]);
    end
    run(misc_sys_pkg::OP_READ_SPECIAL, misc_sys_pkg::SR_MAX_PRIO_ALIAS, 0, 0);
    check({rd_valid, rd_data}, 33'h1_0000_0030);
    run(misc_sys_pkg::OP_WRITE_SPECIAL, misc_sys_pkg::SR_FAULT_MASK, 1, 0);
    check(fault_mask, 1);
    run(misc_sys_pkg::OP_READ_SPECIAL, misc_sys_pkg::SR_FAULT_MASK, 0, 0);
    check({rd_valid, rd_data}, 33'h1_0000_0001);
    run(misc_sys_pkg::OP_WRITE_SPECIAL, misc_sys_pkg::SR_BASE_PRIO, 0, 0);
    check(base_prio, 0);
    run(misc_sys_pkg::OP_SEND_EVENT, 0, 0, 0);
    check({sev_out, event_reg}, 2'b11);
    run(misc_sys_pkg::OP_WAIT_EVENT, 0, 0, 0);
    check({sleeping, event_reg}, 2'b00);
    // Each qualifying wake source in turn; the wake consumes the event.
    for (int i = 0; i < 4; i++) begin
      run(misc_sys_pkg::OP_WAIT_EVENT, 0, 0, 0);
      check(sleeping, 1);
      {exc_unmasked, exc_new_pending, debug_req, ext_event} = 4'h8 >> i;
      wake_wait();
      check({sleeping, event_reg}, 0);
    end
    run(misc_sys_pkg::OP_WAIT_EVENT, 0, 0, 0);
    debug_enabled = 1'b0;
    {debug_req, exc_any} = 2'b11;
    idle(5);
    check(sleeping, 1);
    exc_unmasked = 1'b1;
    wake_wait();
    for (int i = 0; i < 2; i++) begin
      run(misc_sys_pkg::OP_WAIT_INTERRUPT, 0, 0, 0);
      check(sleeping, 1);
      {debug_req, exc_any} = 2'b10 >> i;
      wake_wait();
      check(sleeping, 0);
    end
    kick();
    run(misc_sys_pkg::OP_DSB, 0, 0, 0);
    check({waited >= 2, mem_outstanding}, 2'b10);
    later = 1'b1;
    kick();
    run(misc_sys_pkg::OP_DMB, 0, 0, 0);
    check(mem_issue_allow, 0);
    run(misc_sys_pkg::OP_NOP, 0, 0, 0);
    check(waited, 0);
    idle(6);
    check({mem_issue_allow, mem_outstanding}, 2'b10);
    later = 1'b0;
    run(misc_sys_pkg::OP_ISB, 0, 0, 0);
    check(pipeline_flush, 1);
    cp = 1'b0;
    run(misc_sys_pkg::OP_SUPERVISOR_CALL, 0, 32'h32, 0);
    check(svc_req, 0);
    cp = 1'b1;
    run(misc_sys_pkg::OP_SUPERVISOR_CALL, 0, 32'h5A, 0);
    check({svc_req, svc_imm}, 9'h15A);
    check(program_status_reg, exp_psr);
    {cp, icb} = 2'b01;
    run(misc_sys_pkg::OP_BREAKPOINT, 0, 32'hAB, 0);
    check({halted, breakpoint_instr_imm}, 9'h1AB);
    check(program_status_reg, exp_psr);
    reset = 1'b1;
    idle(2);
    reset = 1'b0;
    check({halted, event_reg, program_status_reg}, {2'b00, misc_sys_pkg::PSR_RESET});
    idle(2);
    print_verdict();
  end

  // Watchdog: the whole sequence needs well under a thousand cycles.
  initial begin
    repeat (3000) @(posedge clk);
    miscompares++;
    print_verdict();
  end
endmodule : testbench
